// >>> inc/gp_pkg.sv
// Constants shared by the general-purpose pin block
package gp_pkg;
	localparam int unsigned GP_PINS = 16;
	localparam int unsigned GP_PORTS = 3;
	localparam int unsigned GP_P1_BASE = 8;
	localparam int unsigned GP_P2_BASE = 13;

	// Register groups: byte address = group base + 4 * port
	localparam logic [3:0] GP_GRP_DATA = 4'h0;
	localparam logic [3:0] GP_GRP_SEL = 4'h1;
	localparam logic [3:0] GP_GRP_DIR = 4'h2;
	localparam logic [3:0] GP_GRP_PULLDIS = 4'h3;
	localparam logic [3:0] GP_GRP_IEN = 4'h4;
	localparam logic [3:0] GP_GRP_IFG = 4'h5;
	localparam logic [3:0] GP_GRP_MISC = 4'h6;
	localparam logic [3:0] GP_GRP_MISC2 = 4'h7;

	// Single registers
	localparam logic [7:0] GP_ADDR_BITOP = 8'h60;
	localparam logic [7:0] GP_ADDR_PULL = 8'h64;
	localparam logic [7:0] GP_ADDR_EDGE = 8'h68;
	localparam logic [7:0] GP_ADDR_ANALOG = 8'h6C;
	localparam logic [7:0] GP_ADDR_PRIO = 8'h70;
	localparam logic [7:0] GP_ADDR_CPU_IEN = 8'h74;
	localparam logic [7:0] GP_ADDR_SLEEP = 8'h78;

	// Bit operation fields
	localparam int unsigned GP_BITOP_BIT_LSB = 0;
	localparam int unsigned GP_BITOP_PORT_LSB = 4;
	localparam int unsigned GP_BITOP_VAL = 8;

	// Reset values
	localparam logic [15:0] GP_RST_LATCH = 16'hFFFF;
	localparam logic [15:0] GP_RST_ZERO16 = 16'h0000;
	localparam logic [15:0] GP_RST_OE_N = 16'hFFFF;
	localparam logic [15:0] GP_RST_PULL_UP = 16'hF8FF;
	localparam logic [15:0] GP_NO_PULL_MASK = 16'h0700;
	localparam logic [4:0] GP_RST_PULL_POL = 5'h1F;
	localparam logic [7:0] GP_RST_ANALOG = 8'h00;
	localparam logic [2:0] GP_RST_EDGE = 3'h0;
	localparam logic [2:0] GP_RST_CPU_IEN = 3'h0;
	localparam logic [1:0] GP_RST_SLEEP = 2'h0;
	localparam logic GP_RST_PRIO = 1'b0;

	typedef enum logic [1:0] {
		GP_AWAKE = 2'b00,
		GP_SLEEP_ONE = 2'b01,
		GP_SLEEP_TWO = 2'b11,
		GP_SLEEP_THREE = 2'b10
	} gp_sleep_type;
endpackage

// >>> inc/gp_pin_if.sv
// Synchronised pin levels and edge pulses between the pin front end and the core
`timescale 1ns/10ps
`default_nettype none
interface gp_pin_if;
	logic [15:0] level;
	logic [15:0] rise;
	logic [15:0] fall;
	modport src (output level, output rise, output fall);
	modport dst (input level, input rise, input fall);
endinterface
`default_nettype wire

// >>> rtl/gp_pin_sync.sv
// Two-stage pin synchroniser with rising and falling edge pulses
`timescale 1ns/10ps
`default_nettype none
module gp_pin_sync
	import gp_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [15:0] pin_in,
	gp_pin_if.src sync
);
	logic [15:0] meta;
	logic [15:0] stable;
	logic [15:0] prev;

	// First stage feeds only the second stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta <= GP_RST_LATCH;
			stable <= GP_RST_LATCH;
		end else begin
			meta <= pin_in;
			stable <= meta;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev <= GP_RST_LATCH;
		end else begin
			prev <= stable;
		end
	end

	assign sync.level = stable;
	assign sync.rise = stable & ~prev;
	assign sync.fall = ~stable & prev;
endmodule
`default_nettype wire

// >>> rtl/gp_port_core.sv
// General-purpose pin block: APB registers, pin muxing, pulls, edge flags
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module gp_port_core
	import gp_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] pin_in,
	output logic [15:0] pin_out,
	output logic [15:0] pin_oe_n,
	output logic [15:0] pull_up_en,
	output logic [15:0] pull_down_en,
	input wire logic [15:0] serial_out,
	input wire logic [15:0] serial_drive,
	input wire logic [15:0] timer1_out,
	input wire logic [15:0] timer1_drive,
	input wire logic [15:0] aux_out,
	input wire logic [15:0] aux_drive,
	output logic [15:0] periph_in,
	output logic [7:0] adc_input_select,
	output logic port0_dma_trigger,
	output logic port1_dma_trigger,
	output logic [2:0] cpu_port_irq_req
);
	gp_pin_if sync ();

	logic [15:0] out_latch;
	logic [15:0] pin_function_select;
	logic [15:0] pin_direction;
	logic [15:0] input_pull_disable;
	logic [15:0] pin_irq_enable;
	logic [15:0] pin_irq_flags;
	logic [4:0] pull_polarity_group;
	logic [2:0] edge_config;
	logic [7:0] analog_pin_config;
	logic port0_serial_timer_priority;
	logic [2:0] cpu_port_common_irq_enable;
	gp_sleep_type sleep_mode;

	logic [15:0] edge_hit;
	logic [15:0] next_pin_out;
	logic [15:0] next_pin_oe_n;
	logic [15:0] next_pull_up;
	logic [15:0] next_pull_down;
	logic [3:0] grp;
	logic [1:0] port;
	logic port_ok;
	logic single_ok;
	logic mapped;
	logic wr;
	logic [31:0] next_rdata;

	gp_pin_sync u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin_in(pin_in),
		.sync(sync.src)
	);

	function automatic logic [7:0] get_port(input logic [15:0] v, input logic [1:0] idx);
		case (idx)
			2'd0: get_port = v[7:0];
			2'd1: get_port = {3'b000, v[12:8]};
			2'd2: get_port = {5'b0_0000, v[15:13]};
			default: get_port = 8'h00;
		endcase
	endfunction

	function automatic logic [15:0] put_port(input logic [15:0] v, input logic [1:0] idx, input logic [7:0] b);
		put_port = v;
		case (idx)
			2'd0: put_port[7:0] = b;
			2'd1: put_port[12:8] = b[4:0];
			2'd2: put_port[15:13] = b[2:0];
			default: put_port = v;
		endcase
	endfunction

	function automatic logic [1:0] port_of(input int unsigned i);
		if (i < GP_P1_BASE) begin
			port_of = 2'd0;
		end else if (i < GP_P2_BASE) begin
			port_of = 2'd1;
		end else begin
			port_of = 2'd2;
		end
	endfunction

	// Four-pin pull groups up to P1.3, then P1.4 alone and port 2 as one; P1.3 shares a group with pins that lack pulls
	function automatic int unsigned pull_group(input int unsigned i);
		if (i < GP_P2_BASE) begin
			pull_group = i / 4;
		end else begin
			pull_group = 4;
		end
	endfunction

	// Address decode
	assign grp = paddr[7:4];
	assign port = paddr[3:2];
	assign port_ok = (port != 2'd3) && (paddr[1:0] == 2'b00) && (grp <= GP_GRP_IFG);
	assign single_ok = (paddr == GP_ADDR_BITOP) || (paddr == GP_ADDR_PULL) ||
		(paddr == GP_ADDR_EDGE) || (paddr == GP_ADDR_ANALOG) ||
		(paddr == GP_ADDR_PRIO) || (paddr == GP_ADDR_CPU_IEN) ||
		(paddr == GP_ADDR_SLEEP);
	assign mapped = port_ok || single_ok;
	assign wr = psel && penable && pwrite && mapped;

	// Zero wait states; error on unmapped addresses
	assign pready = penable;
	assign pslverr = psel && penable && !mapped;

	always_comb begin
		next_rdata = 32'h0000_0000;
		if (port_ok) begin
			case (grp)
				GP_GRP_DATA: next_rdata[7:0] = get_port(sync.level, port);
				GP_GRP_SEL: next_rdata[7:0] = get_port(pin_function_select, port);
				GP_GRP_DIR: next_rdata[7:0] = get_port(pin_direction, port);
				GP_GRP_PULLDIS: next_rdata[7:0] = get_port(input_pull_disable, port);
				GP_GRP_IEN: next_rdata[7:0] = get_port(pin_irq_enable, port);
				GP_GRP_IFG: next_rdata[7:0] = get_port(pin_irq_flags, port);
				default: next_rdata = 32'h0000_0000;
			endcase
		end else begin
			case (paddr)
				GP_ADDR_PULL: next_rdata[4:0] = pull_polarity_group;
				GP_ADDR_EDGE: next_rdata[2:0] = edge_config;
				GP_ADDR_ANALOG: next_rdata[7:0] = analog_pin_config;
				GP_ADDR_PRIO: next_rdata[0] = port0_serial_timer_priority;
				GP_ADDR_CPU_IEN: next_rdata[2:0] = cpu_port_common_irq_enable;
				GP_ADDR_SLEEP: next_rdata[1:0] = sleep_mode;
				default: next_rdata = 32'h0000_0000;
			endcase
		end
	end

	// Captured in the setup cycle so the access phase sees a stable word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= next_rdata;
		end
	end

	// Output latch: byte writes and single-bit operations
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_latch <= GP_RST_LATCH;
		end else if (wr && port_ok && grp == GP_GRP_DATA) begin
			out_latch <= put_port(out_latch, port, pwdata[7:0]);
		end else if (wr && paddr == GP_ADDR_BITOP) begin
			// Latch, not pin, is the source so input pins keep their latch bits, not their levels
			out_latch <= put_port(out_latch, pwdata[GP_BITOP_PORT_LSB +: 2],
				get_port(out_latch, pwdata[GP_BITOP_PORT_LSB +: 2]) &
				~(8'h01 << pwdata[GP_BITOP_BIT_LSB +: 3]) |
				({7'h00, pwdata[GP_BITOP_VAL]} << pwdata[GP_BITOP_BIT_LSB +: 3]));
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_function_select <= GP_RST_ZERO16;
		end else if (wr && port_ok && grp == GP_GRP_SEL) begin
			pin_function_select <= put_port(pin_function_select, port, pwdata[7:0]);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_direction <= GP_RST_ZERO16;
		end else if (wr && port_ok && grp == GP_GRP_DIR) begin
			pin_direction <= put_port(pin_direction, port, pwdata[7:0]);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			input_pull_disable <= GP_RST_ZERO16;
		end else if (wr && port_ok && grp == GP_GRP_PULLDIS) begin
			input_pull_disable <= put_port(input_pull_disable, port, pwdata[7:0]);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_irq_enable <= GP_RST_ZERO16;
		end else if (wr && port_ok && grp == GP_GRP_IEN) begin
			pin_irq_enable <= put_port(pin_irq_enable, port, pwdata[7:0]);
		end
	end

	// Edge selection per port
	always_comb begin
		for (int unsigned i = 0; i < GP_PINS; i++) begin
			edge_hit[i] = edge_config[port_of(i)] ? sync.fall[i] : sync.rise[i];
		end
	end

	// Flags: a new edge wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_irq_flags <= GP_RST_ZERO16;
		end else if (wr && port_ok && grp == GP_GRP_IFG) begin
			pin_irq_flags <= (pin_irq_flags & put_port(16'hFFFF, port, pwdata[7:0])) | edge_hit;
		end else begin
			pin_irq_flags <= pin_irq_flags | edge_hit;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pull_polarity_group <= GP_RST_PULL_POL;
			edge_config <= GP_RST_EDGE;
			analog_pin_config <= GP_RST_ANALOG;
			port0_serial_timer_priority <= GP_RST_PRIO;
			cpu_port_common_irq_enable <= GP_RST_CPU_IEN;
			sleep_mode <= GP_AWAKE;
		end else if (wr) begin
			case (paddr)
				GP_ADDR_PULL: pull_polarity_group <= pwdata[4:0];
				GP_ADDR_EDGE: edge_config <= pwdata[2:0];
				GP_ADDR_ANALOG: analog_pin_config <= pwdata[7:0];
				GP_ADDR_PRIO: port0_serial_timer_priority <= pwdata[0];
				GP_ADDR_CPU_IEN: cpu_port_common_irq_enable <= pwdata[2:0];
				GP_ADDR_SLEEP: sleep_mode <= gp_sleep_type'(pwdata[1:0]);
				default: sleep_mode <= sleep_mode;
			endcase
		end
	end

	// Pin drive and pull resolution
	always_comb begin
		logic analog;
		logic per_drive;
		logic per_val;
		logic drive;
		logic pull_on;
		analog = 1'b0;
		per_drive = 1'b0;
		per_val = 1'b0;
		drive = 1'b0;
		pull_on = 1'b0;
		next_pin_out = 16'h0000;
		next_pin_oe_n = 16'hFFFF;
		next_pull_up = 16'h0000;
		next_pull_down = 16'h0000;
		for (int unsigned i = 0; i < GP_PINS; i++) begin
			analog = (i < GP_P1_BASE) ? analog_pin_config[i[2:0]] : 1'b0;
			per_drive = serial_drive[i] || timer1_drive[i] || aux_drive[i];
			// Only drivers compete; readers never arbitrate
			if (serial_drive[i] && timer1_drive[i] && i < GP_P1_BASE) begin
				per_val = port0_serial_timer_priority ? timer1_out[i] : serial_out[i];
			end else if (serial_drive[i]) begin
				per_val = serial_out[i];
			end else if (timer1_drive[i]) begin
				per_val = timer1_out[i];
			end else begin
				per_val = aux_out[i];
			end
			if (analog) begin
				drive = 1'b0;
				next_pin_out[i] = 1'b0;
			end else if (pin_function_select[i]) begin
				drive = per_drive;
				next_pin_out[i] = per_val;
			end else begin
				drive = pin_direction[i];
				next_pin_out[i] = out_latch[i];
			end
			next_pin_oe_n[i] = ~drive;
			pull_on = !analog && !pin_function_select[i] && !drive && !input_pull_disable[i] &&
				!GP_NO_PULL_MASK[i];
			next_pull_up[i] = pull_on && pull_polarity_group[pull_group(i)];
			next_pull_down[i] = pull_on && !pull_polarity_group[pull_group(i)];
		end
	end

	// Pins frozen while asleep
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_out <= GP_RST_LATCH;
			pin_oe_n <= GP_RST_OE_N;
			pull_up_en <= GP_RST_PULL_UP;
			pull_down_en <= GP_RST_ZERO16;
		end else if (sleep_mode == GP_AWAKE) begin
			pin_out <= next_pin_out;
			pin_oe_n <= next_pin_oe_n;
			pull_up_en <= next_pull_up;
			pull_down_en <= next_pull_down;
		end
	end

	// Peripheral inputs see the pin regardless of select
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			periph_in <= GP_RST_LATCH;
			adc_input_select <= GP_RST_ANALOG;
		end else begin
			periph_in <= sync.level;
			adc_input_select <= analog_pin_config;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port0_dma_trigger <= 1'b0;
			port1_dma_trigger <= 1'b0;
		end else begin
			port0_dma_trigger <= |edge_hit[7:0];
			port1_dma_trigger <= |edge_hit[12:8];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_port_irq_req <= 3'b000;
		end else begin
			cpu_port_irq_req[0] <= cpu_port_common_irq_enable[0] && |(pin_irq_flags[7:0] & pin_irq_enable[7:0]);
			cpu_port_irq_req[1] <= cpu_port_common_irq_enable[1] && |(pin_irq_flags[12:8] & pin_irq_enable[12:8]);
			cpu_port_irq_req[2] <= cpu_port_common_irq_enable[2] &&
				|(pin_irq_flags[15:13] & pin_irq_enable[15:13]);
		end
	end
endmodule
`default_nettype wire

// >>> test/gp_port_checker.sv
// Concurrent checks on the ports of the general-purpose pin block
`timescale 1ns/10ps
`default_nettype none
module gp_port_checker
	import gp_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [15:0] pin_in,
	input wire logic [15:0] pin_out,
	input wire logic [15:0] pin_oe_n,
	input wire logic [15:0] pull_up_en,
	input wire logic [15:0] pull_down_en,
	input wire logic [15:0] periph_in,
	input wire logic [7:0] adc_input_select,
	input wire logic port0_dma_trigger,
	input wire logic [2:0] cpu_port_irq_req
);
	logic asleep;
	logic [2:0] cpu_en;
	logic [7:0] ana_w;
	logic [2:0] up_cnt;
	wire logic wr = psel && penable && pwrite;
	// Shadows of the writes that the checks depend on
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			asleep <= 1'b0;
			cpu_en <= 3'h0;
			ana_w <= 8'h00;
		end else if (wr) begin
			asleep <= (paddr == GP_ADDR_SLEEP) ? (pwdata[1:0] != 2'h0) : asleep;
			cpu_en <= (paddr == GP_ADDR_CPU_IEN) ? pwdata[2:0] : cpu_en;
			ana_w <= (paddr == GP_ADDR_ANALOG) ? pwdata[7:0] : ana_w;
		end
	end
	// Pin history before the synchroniser fills says nothing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			up_cnt <= 3'h0;
		end else if (up_cnt != 3'h7) begin
			up_cnt <= up_cnt + 3'h1;
		end
	end
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	reset_pins_a: assert property ($rose(presetn) |->
		pin_oe_n == 16'hFFFF && pull_up_en == 16'hF8FF && pull_down_en == 16'h0000) else $error("bad reset pins");
	no_pull_a: assert property (pull_up_en[10:8] == 3'h0 && pull_down_en[10:8] == 3'h0)
		else $error("pull on pull-less pins");
	pull_excl_a: assert property ((pull_up_en & pull_down_en) == 16'h0000)
		else $error("pullup and pulldown together");
	dma_cause_a: assert property (port0_dma_trigger && up_cnt == 3'h7 |->
		($past(pin_in[7:0], 4) != $past(pin_in[7:0], 3)) || ($past(pin_in[7:0], 3) != $past(pin_in[7:0], 2)))
		else $error("dma trigger without pin edge");
	periph_sync_a: assert property ($stable(pin_in[7:0]) [*5] |-> periph_in[7:0] == pin_in[7:0])
		else $error("peripheral input not pin level");
	sleep_hold_a: assert property ($past(asleep) |->
		$stable(pin_oe_n) && $stable(pin_out) && $stable(pull_up_en) && $stable(pull_down_en))
		else $error("pins changed in sleep");
	irq_gate_a: assert property ((cpu_port_irq_req & ~$past(cpu_en)) == 3'h0)
		else $error("irq without common enable");
	analog_copy_a: assert property (wr && paddr == GP_ADDR_ANALOG |=> ##1 adc_input_select == ana_w)
		else $error("adc select not analog config");
endmodule
bind gp_port_core gp_port_checker chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pull_up_en(pull_up_en),
	.pull_down_en(pull_down_en), .periph_in(periph_in), .adc_input_select(adc_input_select),
	.port0_dma_trigger(port0_dma_trigger), .cpu_port_irq_req(cpu_port_irq_req)
);
`default_nettype wire

// >>> test/gp_pin_model.sv
// Far side of the pins: outside drivers, pull resistors, loose lines
`timescale 1ns/10ps
`default_nettype none
module gp_pin_model (
	input wire logic pclk,
	input wire logic [15:0] pin_out,
	input wire logic [15:0] pin_oe_n,
	input wire logic [15:0] pull_up_en,
	input wire logic [15:0] pull_down_en,
	input wire logic [15:0] ext_val,
	input wire logic [15:0] ext_en,
	output logic [15:0] pin_in
);
	logic [15:0] loose = 16'h0000;
	// A line nobody holds flips each cycle, so no guess settles it
	always_ff @(posedge pclk) begin
		loose <= ~loose;
	end
	// Block drive wins; pulls only act on a line nobody drives
	assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
		| (pin_oe_n & ~ext_en & (pull_up_en | (~pull_down_en & loose)));
endmodule
`default_nettype wire

// >>> test/gp_port_core_bench.sv
// Self-checking bench for the general-purpose pin block
`timescale 1ns/10ps
`default_nettype none
module gp_port_core_bench
	import gp_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, rd;
	logic pready, pslverr, er, dma0, dma1;
	logic [15:0] pin_in, pin_out, pin_oe_n, pull_up_en, pull_down_en, periph_in;
	logic [15:0] ser_d = 16'h0000, tm_d = 16'h0000, tm_o = 16'h0000;
	logic [15:0] ext_val = 16'h0000, ext_en = 16'h17C0;
	logic [7:0] adc_sel;
	logic [2:0] irq;
	int n_errors = 0, compares = 0;
	always #4 pclk = ~pclk;
	gp_port_core dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe_n(pin_oe_n), .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
		.serial_out(16'h0000), .serial_drive(ser_d), .timer1_out(tm_o), .timer1_drive(tm_d),
		.aux_out(16'h0000), .aux_drive(16'h0000), .periph_in(periph_in), .adc_input_select(adc_sel),
		.port0_dma_trigger(dma0), .port1_dma_trigger(dma1), .cpu_port_irq_req(irq)
	);
	gp_pin_model far (.pclk(pclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pull_up_en(pull_up_en),
		.pull_down_en(pull_down_en), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));
	task automatic final_report();
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			n_errors++;
			final_report();
		end
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, 32'(d));
	endtask
	task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(what, 32'(exp), rd);
	endtask
	task automatic dma_wait(output logic s0, output logic s1);
		s0 = 1'b0;
		s1 = 1'b0;
		repeat (10) begin
			@(posedge pclk);
			s0 = s0 | (dma0 === 1'b1);
			s1 = s1 | (dma1 === 1'b1);
		end
	endtask
	task automatic t_reset();
		chk("oe_n", 32'h0000_FFFF, 32'(pin_oe_n));
		chk("pull_up", 32'h0000_F8FF, 32'(pull_up_en));
		rdchk("sel0", 8'h10, 8'h00);
		rdchk("analog", 8'h6C, 8'h00);
		rdchk("port0", 8'h00, 8'h3F);
		// Trigger pin left a plain input so the converter sees the pin
		wr(8'h18, 8'h00);
		wr(8'h28, 8'h00);
		repeat (2) @(posedge pclk);
		chk("trig_oe", 32'h0000_0001, 32'(pin_oe_n[13]));
		rdchk("port2", 8'h08, 8'h07);
		rdchk("unmapped", 8'h7C, 8'h00);
		chk("slverr", 32'h0000_0001, 32'(er));
	endtask
	task automatic t_gpio();
		wr(8'h20, 8'h0F);
		wr(8'h00, 8'hA5);
		repeat (4) @(posedge pclk);
		chk("oe_n0", 32'h0000_00F0, 32'(pin_oe_n[7:0]));
		rdchk("port0", 8'h00, 8'h35);
		// Clearing bit 0 must keep latch bits of input pins, not their levels
		apb(1'b1, 8'h60, 32'h0000_0000);
		wr(8'h20, 8'hFF);
		repeat (2) @(posedge pclk);
		chk("latch0", 32'h0000_00A4, 32'(pin_out[7:0]));
		wr(8'h20, 8'h0F);
	endtask
	task automatic t_pull();
		wr(8'h10, 8'h10);
		wr(8'h30, 8'h20);
		wr(8'h64, 8'h1C);
		repeat (2) @(posedge pclk);
		chk("pull_dn", 32'h0000_000C, 32'(pull_down_en[7:4]));
		chk("pull_up", 32'h0000_0000, 32'(pull_up_en[7:4]));
		chk("pull_p1", 32'h0000_0001, 32'(pull_up_en[12]));
		wr(8'h64, 8'h14);
		repeat (2) @(posedge pclk);
		chk("pull_p1", 32'h0000_0001, 32'(pull_down_en[12]));
		wr(8'h64, 8'h1F);
		wr(8'h30, 8'h00);
	endtask
	task automatic t_periph();
		ser_d <= 16'h0010;
		tm_d <= 16'h0010;
		tm_o <= 16'h0010;
		repeat (3) @(posedge pclk);
		chk("serial", 32'h0000_0000, 32'({pin_oe_n[4], pin_out[4]}));
		wr(8'h70, 8'h01);
		repeat (2) @(posedge pclk);
		chk("timer1", 32'h0000_0001, 32'({pin_oe_n[4], pin_out[4]}));
		// Lone driver passes whatever the priority bit says
		ser_d <= 16'h0000;
		wr(8'h70, 8'h00);
		repeat (2) @(posedge pclk);
		chk("timer_only", 32'h0000_0001, 32'({pin_oe_n[4], pin_out[4]}));
		chk("periph_in", 32'h0000_0000, 32'(periph_in[7:6]));
		wr(8'h10, 8'h00);
		wr(8'h6C, 8'h08);
		repeat (3) @(posedge pclk);
		chk("gp_oe", 32'h0000_0001, 32'(pin_oe_n[4]));
		chk("adc", 32'h0000_0108, 32'({pin_oe_n[3], adc_sel}));
		wr(8'h6C, 8'h00);
		ser_d <= 16'h0000;
		tm_d <= 16'h0000;
	endtask
	task automatic t_irq();
		logic s0, s1;
		// Let the analog pin settle; a late edge would beat the clear
		repeat (4) @(posedge pclk);
		wr(8'h50, 8'h00);
		ext_val <= 16'h1040;
		dma_wait(s0, s1);
		chk("dma0", 32'h0000_0001, 32'(s0));
		rdchk("flag0", 8'h50, 8'h40);
		wr(8'h50, 8'hFF);
		rdchk("flag0", 8'h50, 8'h40);
		wr(8'h40, 8'h40);
		wr(8'h74, 8'h01);
		repeat (2) @(posedge pclk);
		chk("irq0", 32'h0000_0001, 32'(irq[0]));
		wr(8'h50, 8'h00);
		repeat (2) @(posedge pclk);
		chk("irq_clr", 32'h0000_0000, 32'(irq[0]));
		wr(8'h00, 8'hA5);
		repeat (6) @(posedge pclk);
		rdchk("flag0", 8'h50, 8'h01);
		chk("irq0", 32'h0000_0000, 32'(irq[0]));
		wr(8'h68, 8'h02);
		wr(8'h54, 8'h00);
		ext_val <= 16'h0040;
		dma_wait(s0, s1);
		chk("dma1", 32'h0000_0001, 32'(s1));
		chk("dma0_idle", 32'h0000_0000, 32'(s0));
		rdchk("flag1", 8'h54, 8'h10);
	endtask
	task automatic t_sleep();
		logic [1:0] modes [3] = '{2'h1, 2'h3, 2'h2};
		foreach (modes[i]) begin
			wr(8'h78, 8'(modes[i]));
			wr(8'h20, 8'h00);
			repeat (3) @(posedge pclk);
			chk("sleep_oe", 32'h0000_00F0, 32'(pin_oe_n[7:0]));
			wr(8'h78, 8'h00);
			repeat (3) @(posedge pclk);
			chk("wake_oe", 32'h0000_00FF, 32'(pin_oe_n[7:0]));
			wr(8'h20, 8'h0F);
		end
	endtask
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_gpio();
		t_pull();
		t_periph();
		t_irq();
		t_sleep();
		final_report();
	end
endmodule
`default_nettype wire
